// file: ssp_pkg.sv
package ssp_pkg;
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_BUF = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IST = 8'h0c;
  localparam logic [7:0] ADDR_IEN = 8'h10;
  localparam logic [7:0] ADDR_ICLR = 8'h14;
  localparam int WRITE_COLLISION_FLAG_BIT = 7;
  localparam int OVF_BIT = 6;
  localparam int EN_BIT = 5;
  localparam int CKP_BIT = 4;
  localparam int STAT_BF_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int EV_DONE = 0;
  localparam int EV_WRITE_COLLISION_FLAG = 1;
  localparam int EV_OVF = 2;
  localparam int NEV = 3;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [3:0] MODE_SPIM_DIV4 = 4'h0;
  localparam logic [3:0] MODE_SPIM_DIV16 = 4'h1;
  localparam logic [3:0] MODE_SPIM_DIV64 = 4'h2;
  localparam logic [3:0] MODE_SPIM_TMR = 4'h3;
  localparam logic [3:0] MODE_SPIS_SEL = 4'h4;
  localparam logic [3:0] MODE_SPIS_NOSEL = 4'h5;
  localparam logic [3:0] MODE_I2CS_7 = 4'h6;
  localparam logic [3:0] MODE_I2CS_10 = 4'h7;
  localparam logic [3:0] MODE_I2CM = 4'h8;
  localparam logic [3:0] MODE_SPIM_ADD = 4'ha;
  localparam logic [3:0] MODE_I2CM_FW = 4'hb;
  localparam logic [3:0] MODE_I2CS_7I = 4'he;
  localparam logic [3:0] MODE_I2CS_10I = 4'hf;
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [3:0] NBITS = 4'h8;
  localparam int PIN_SCK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_SDO = 2;
  localparam int PIN_SS = 3;
  localparam int NPIN = 4;

  typedef enum logic [0:0] {SSP_IDLE, SSP_RUN} ssp_phase_t;

  typedef struct packed {
    logic [NPIN-1:0] o;
    logic [NPIN-1:0] oe;
  } ssp_pins_t;

  typedef struct packed {
    ssp_phase_t phase;
    logic [7:0] ctrl;
    logic [7:0] buf_q;
    logic bf;
    logic [7:0] sr;
    logic rbit;
    logic [3:0] cnt;
    logic [5:0] div;
    logic sck_o;
    logic sck_q;
    logic [NEV-1:0] ist;
    logic [NEV-1:0] ien;
    logic [31:0] prdata;
  } ssp_state_t;
endpackage

// file: ssp_sync.sv
`timescale 1ns/1ps
module ssp_sync #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// file: ssp_port.sv
`timescale 1ns/1ps
// Summary of operation
// - Buffer write while transmitting sets collision flag
// - Slave byte into full buffer sets overflow
// - On overflow drop shifted byte, keep buffer
// - Overflow never raised in master operation
// - SPI enable hands SCK, SDO, SDI, SS pins
// - I2C enable hands SDA and SCL pins
// - Enable cleared disables port, pins to GPIO
module ssp_port #(
  parameter logic [5:0] ALT_HALF = 6'h02
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ssp_pkg::NPIN-1:0] pin_i,
  output ssp_pkg::ssp_pins_t pin,
  input wire ssp_pkg::ssp_pins_t gpio,
  output logic irq
);
  ssp_pkg::ssp_state_t s_r;
  ssp_pkg::ssp_state_t s_nxt;
  logic [ssp_pkg::NPIN-1:0] pin_s;
  logic en;
  logic clock_polarity_hold_bit;
  logic [3:0] mode;
  logic is_i2c;
  logic spi_m;
  logic spi_s;
  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic mapped;
  logic lead;
  logic trail;
  logic ss_idle;
  logic busy;
  logic buf_wr;
  localparam int NEV_W = ssp_pkg::NEV;
  logic [5:0] half;
  logic [NEV_W-1:0] ev;
  logic din;

  ssp_sync #(.W(ssp_pkg::NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_i),
    .q(pin_s)
  );

  assign en = s_r.ctrl[ssp_pkg::EN_BIT];
  assign clock_polarity_hold_bit = s_r.ctrl[ssp_pkg::CKP_BIT];
  assign mode = s_r.ctrl[3:0];
  assign is_i2c = mode inside {ssp_pkg::MODE_I2CS_7, ssp_pkg::MODE_I2CS_10,
    ssp_pkg::MODE_I2CM, ssp_pkg::MODE_I2CM_FW, ssp_pkg::MODE_I2CS_7I,
    ssp_pkg::MODE_I2CS_10I};
  assign spi_m = mode inside {ssp_pkg::MODE_SPIM_DIV4,
    ssp_pkg::MODE_SPIM_DIV16, ssp_pkg::MODE_SPIM_DIV64,
    ssp_pkg::MODE_SPIM_TMR, ssp_pkg::MODE_SPIM_ADD};
  assign spi_s = mode inside {ssp_pkg::MODE_SPIS_SEL,
    ssp_pkg::MODE_SPIS_NOSEL};
  assign ss_idle = (mode == ssp_pkg::MODE_SPIS_SEL) && pin_s[ssp_pkg::PIN_SS];
  assign busy = (s_r.phase == ssp_pkg::SSP_RUN) || (s_r.cnt != 4'h0);
  // The master takes its bit at the trailing edge, because the synchroniser
  // delays SDI by two cycles and the fastest divider would otherwise see
  // the previous bit at the leading edge.
  assign din = spi_m ? pin_s[ssp_pkg::PIN_SDI] : s_r.rbit;

  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign mapped = paddr inside {ssp_pkg::ADDR_CTRL1, ssp_pkg::ADDR_BUF,
    ssp_pkg::ADDR_STAT, ssp_pkg::ADDR_IST, ssp_pkg::ADDR_IEN,
    ssp_pkg::ADDR_ICLR};
  assign buf_wr = acc_wr && (paddr == ssp_pkg::ADDR_BUF);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_r.prdata;
  assign irq = |(s_r.ist & s_r.ien);

  always_comb
  begin
    case (mode)
      ssp_pkg::MODE_SPIM_DIV16: half = ssp_pkg::HALF_DIV16;
      ssp_pkg::MODE_SPIM_DIV64: half = ssp_pkg::HALF_DIV64;
      ssp_pkg::MODE_SPIM_TMR, ssp_pkg::MODE_SPIM_ADD: half = ALT_HALF;
      default: half = ssp_pkg::HALF_DIV4;
    endcase
  end

  // Slave edges come from the synchronised pin; master edges from the
  // divider, so both share one shift path.
  always_comb
  begin
    lead = 1'b0;
    trail = 1'b0;
    if (spi_s && !ss_idle)
    begin
      lead = (pin_s[ssp_pkg::PIN_SCK] != clock_polarity_hold_bit) && (s_r.sck_q == clock_polarity_hold_bit);
      trail = (pin_s[ssp_pkg::PIN_SCK] == clock_polarity_hold_bit) && (s_r.sck_q != clock_polarity_hold_bit);
    end
    else if (spi_m && s_r.phase == ssp_pkg::SSP_RUN && s_r.div == 6'h01)
    begin
      lead = (s_r.sck_o == clock_polarity_hold_bit);
      trail = (s_r.sck_o != clock_polarity_hold_bit);
    end
  end

  always_comb
  begin
    s_nxt = s_r;
    ev = '0;
    s_nxt.sck_q = pin_s[ssp_pkg::PIN_SCK];
    if (setup)
    begin
      case (paddr)
        ssp_pkg::ADDR_CTRL1: s_nxt.prdata = {24'h000000, s_r.ctrl};
        ssp_pkg::ADDR_BUF: s_nxt.prdata = {24'h000000, s_r.buf_q};
        ssp_pkg::ADDR_STAT: s_nxt.prdata = {30'h00000000, busy, s_r.bf};
        ssp_pkg::ADDR_IST: s_nxt.prdata = {29'h00000000, s_r.ist};
        ssp_pkg::ADDR_IEN: s_nxt.prdata = {29'h00000000, s_r.ien};
        default: s_nxt.prdata = 32'h00000000;
      endcase
    end
    if (acc_rd && paddr == ssp_pkg::ADDR_BUF)
      s_nxt.bf = 1'b0;
    if (acc_wr)
    begin
      case (paddr)
        ssp_pkg::ADDR_CTRL1:
        begin
          s_nxt.ctrl[5:0] = pwdata[5:0];
          s_nxt.ctrl[7:6] = s_r.ctrl[7:6] & pwdata[7:6];
        end
        ssp_pkg::ADDR_IEN: s_nxt.ien = pwdata[NEV_W-1:0];
        ssp_pkg::ADDR_ICLR: s_nxt.ist = s_r.ist & ~pwdata[NEV_W-1:0];
        default: ;
      endcase
    end
    if (en && !is_i2c && buf_wr)
    begin
      if (busy)
        ev[ssp_pkg::EV_WRITE_COLLISION_FLAG] = 1'b1;
      else
      begin
        s_nxt.sr = pwdata[7:0];
        if (spi_m)
        begin
          s_nxt.phase = ssp_pkg::SSP_RUN;
          s_nxt.div = half;
        end
      end
    end
    if (en && spi_m && s_r.phase == ssp_pkg::SSP_RUN)
    begin
      s_nxt.div = (s_r.div == 6'h01) ? half : s_r.div - 6'h01;
      if (lead || trail)
        s_nxt.sck_o = ~s_r.sck_o;
    end
    if (lead)
      s_nxt.rbit = pin_s[ssp_pkg::PIN_SDI];
    if (trail)
    begin
      s_nxt.sr = {s_r.sr[6:0], din};
      s_nxt.cnt = s_r.cnt + 4'h1;
      if (s_r.cnt == ssp_pkg::NBITS - 4'h1)
      begin
        s_nxt.cnt = 4'h0;
        s_nxt.phase = ssp_pkg::SSP_IDLE;
        ev[ssp_pkg::EV_DONE] = 1'b1;
        if (spi_s && s_r.bf)
          ev[ssp_pkg::EV_OVF] = 1'b1;
        else
        begin
          s_nxt.buf_q = {s_r.sr[6:0], din};
          s_nxt.bf = 1'b1;
        end
      end
    end
    if (spi_s && ss_idle)
      s_nxt.cnt = 4'h0;
    if (s_nxt.phase == ssp_pkg::SSP_IDLE)
      s_nxt.sck_o = s_nxt.ctrl[ssp_pkg::CKP_BIT];
    // Hardware sets beat a simultaneous software clear.
    if (ev[ssp_pkg::EV_WRITE_COLLISION_FLAG])
      s_nxt.ctrl[ssp_pkg::WRITE_COLLISION_FLAG_BIT] = 1'b1;
    if (ev[ssp_pkg::EV_OVF])
      s_nxt.ctrl[ssp_pkg::OVF_BIT] = 1'b1;
    s_nxt.ist = s_nxt.ist | ev;
    if (!s_nxt.ctrl[ssp_pkg::EN_BIT])
    begin
      s_nxt.phase = ssp_pkg::SSP_IDLE;
      s_nxt.cnt = 4'h0;
      s_nxt.bf = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.ctrl <= ssp_pkg::CTRL1_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // Pin ownership; while enabled the peripheral sets all four pad directions in SPI, only SCK and SDI in I2C; GPIO otherwise.
  always_comb
  begin
    pin = gpio;
    if (en && !is_i2c)
    begin
      pin.o[ssp_pkg::PIN_SCK] = s_r.sck_o;
      pin.oe[ssp_pkg::PIN_SCK] = spi_m;
      pin.o[ssp_pkg::PIN_SDO] = s_r.sr[7];
      pin.oe[ssp_pkg::PIN_SDO] = spi_m || (spi_s && !ss_idle);
      pin.o[ssp_pkg::PIN_SDI] = 1'b0;
      pin.oe[ssp_pkg::PIN_SDI] = 1'b0;
      pin.o[ssp_pkg::PIN_SS] = 1'b0;
      pin.oe[ssp_pkg::PIN_SS] = 1'b0;
    end
    else if (en)
    begin
      // Open-drain style: SCL is only ever pulled low, SDA left released.
      pin.o[ssp_pkg::PIN_SCK] = 1'b0;
      pin.oe[ssp_pkg::PIN_SCK] = mode[2] && mode[1] && !clock_polarity_hold_bit;
      pin.o[ssp_pkg::PIN_SDI] = 1'b0;
      pin.oe[ssp_pkg::PIN_SDI] = 1'b0;
    end
  end

  sequence s_slave_full_done;
    spi_s && s_r.bf && trail && s_r.cnt == 4'h7;
  endsequence

  property p_write_collision_flag_set;
    @(posedge pclk) disable iff (!presetn)
      en && !is_i2c && buf_wr && busy |=> s_r.ctrl[ssp_pkg::WRITE_COLLISION_FLAG_BIT];
  endproperty
  a_write_collision_flag_set: assert property (p_write_collision_flag_set)
    else $error("collision flag not set on busy buffer write");

  property p_ovf_set;
    @(posedge pclk) disable iff (!presetn)
      s_slave_full_done ##0 en |=> s_r.ctrl[ssp_pkg::OVF_BIT];
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set");

  property p_ovf_keep;
    @(posedge pclk) disable iff (!presetn)
      s_slave_full_done ##0 !acc_rd ##0 en |=> s_r.buf_q == $past(s_r.buf_q);
  endproperty
  a_ovf_keep: assert property (p_ovf_keep)
    else $error("buffer overwritten on overflow");

  property p_no_ovf_master;
    @(posedge pclk) disable iff (!presetn)
      spi_m && !$past(spi_s) && !acc_wr
        |=> !$rose(s_r.ctrl[ssp_pkg::OVF_BIT]);
  endproperty
  a_no_ovf_master: assert property (p_no_ovf_master)
    else $error("overflow raised in master mode");

  property p_spi_pins;
    @(posedge pclk) disable iff (!presetn)
      en && spi_m |-> pin.oe[ssp_pkg::PIN_SCK] && pin.oe[ssp_pkg::PIN_SDO]
        && pin.o[ssp_pkg::PIN_SDO] == s_r.sr[7];
  endproperty
  a_spi_pins: assert property (p_spi_pins)
    else $error("SPI master pins not driven");

  property p_gpio_back;
    @(posedge pclk) disable iff (!presetn)
      !en |-> pin == gpio && s_r.phase == ssp_pkg::SSP_IDLE;
  endproperty
  a_gpio_back: assert property (p_gpio_back)
    else $error("pins not returned to GPIO while disabled");

  property p_scl_hold;
    @(posedge pclk) disable iff (!presetn)
      en && (mode == ssp_pkg::MODE_I2CS_7) && !clock_polarity_hold_bit |->
        pin.oe[ssp_pkg::PIN_SCK] && !pin.o[ssp_pkg::PIN_SCK];
  endproperty
  a_scl_hold: assert property (p_scl_hold)
    else $error("SCL not held low in I2C slave");

  property p_idle_level;
    @(posedge pclk) disable iff (!presetn)
      en && spi_m && s_r.phase == ssp_pkg::SSP_IDLE && $stable(clock_polarity_hold_bit)
        |-> s_r.sck_o == clock_polarity_hold_bit;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("SPI clock idle level wrong");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      ev[ssp_pkg::EV_DONE] && s_r.ien[ssp_pkg::EV_DONE] |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised on transfer done");
endmodule

// file: ssp_peer.sv
`timescale 1ns/1ps
module ssp_peer (
  input wire logic sck_m,
  input wire logic sdo_m,
  output logic sck_s,
  output logic sdi,
  output logic ss_n,
  output logic [7:0] rx
);
  logic [7:0] tx;
  assign sdi = tx[7];
  initial
  begin
    sck_s = 1'h0;
    ss_n = 1'h1;
    rx = 8'h0;
    tx = 8'h0;
  end
  // Sample on the leading edge, shift on the trailing one; the fill bit
  // keeps toggling so a stale line never looks like valid data.
  always @(posedge sck_m) rx <= {rx[6:0], sdo_m};
  always @(negedge sck_m) tx <= {tx[6:0], ~tx[0]};
  task load(input logic [7:0] b);
    tx = b;
  endtask
  // Master role at a 200 ns bit time; the clock stands still between frames.
  task drive(input logic [7:0] b);
    tx = b;
    ss_n = 1'h0;
    #7;
    repeat (8)
    begin
      #100 sck_s = 1'h1;
      #100 sck_s = 1'h0;
    end
    ss_n = 1'h1;
  endtask
endmodule

// file: sync_serial_port_control_tb.sv
`timescale 1ns/1ps
module sync_serial_port_control_tb;
  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] rd;
    logic [3:0] pv;
  } ssp_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic sck, sck_s, sdi, ss_n;
  logic [7:0] paddr, rx;
  logic [31:0] pwdata, prdata, rd;
  logic [ssp_pkg::NPIN-1:0] pin_i;
  ssp_pkg::ssp_pins_t pin, gpio;
  int err_total, checks, cyc, i;
  ssp_row_t rows [11];
  ssp_port ssp_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
    .pin(pin), .gpio(gpio), .irq(irq));
  ssp_peer ssp_peer_inst (.sck_m(sck), .sdo_m(pin.o[2]), .sck_s(sck_s),
    .sdi(sdi), .ss_n(ss_n), .rx(rx));
  assign sck = pin.oe[0] ? pin.o[0] : sck_s;
  assign pin_i = {ss_n, pin.o[2], sdi, sck};
  initial
  begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Return mid-cycle so callers compare outputs once they have settled.
    @(negedge pclk);
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task wait_idle;
    for (int k = 0; k < 50; k++)
    begin
      apb(1'h0, ssp_pkg::ADDR_STAT, 32'h0);
      if (rd[ssp_pkg::STAT_BUSY_BIT] === 1'h0) break;
    end
  endtask
  task slave_byte(input logic [7:0] b);
    ssp_peer_inst.drive(b);
    repeat (8) @(posedge pclk);
  endtask
  function automatic logic [31:0] pinv();
    return {28'h0, pin.oe[2:0], pin.oe[0] ? pin.o[0] : 1'h1};
  endfunction
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    gpio = '{o: 4'hb, oe: 4'h4};
    err_total = 0;
    checks = 0;
    cyc = 0;
    rows = '{'{8'h00, 8'h00, 4'h9}, '{8'h20, 8'h20, 4'ha},
      '{8'h30, 8'h30, 4'hb},
      '{8'h22, 8'h22, 4'ha}, '{8'h26, 8'h26, 4'ha}, '{8'h36, 8'h36, 4'h9},
      '{8'h2e, 8'h2e, 4'ha}, '{8'h27, 8'h27, 4'ha}, '{8'h25, 8'h25, 4'h9},
      '{8'h24, 8'h24, 4'h1}, '{8'hff, 8'h3f, 4'h9}};
    repeat (20) @(posedge pclk);
    chk("reset pins", {24'h0, gpio}, {24'h0, pin});
    presetn <= 1'h1;
    rchk("ctrl reset", ssp_pkg::ADDR_CTRL1, {24'h0, ssp_pkg::CTRL1_RESET});
    for (i = 0; i < 11; i++)
    begin
      apb(1'h1, ssp_pkg::ADDR_CTRL1, {24'h0, rows[i].wr});
      rchk("ctrl", ssp_pkg::ADDR_CTRL1, {24'h0, rows[i].rd});
      chk("pins", {28'h0, rows[i].pv}, pinv());
    end
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("table and map test done");
    apb(1'h1, ssp_pkg::ADDR_IEN, 32'h7);
    apb(1'h1, ssp_pkg::ADDR_CTRL1, 32'h20);
    ssp_peer_inst.load(8'h5a);
    apb(1'h1, ssp_pkg::ADDR_BUF, 32'ha5);
    apb(1'h1, ssp_pkg::ADDR_BUF, 32'h3c);
    wait_idle();
    chk("peer rx", 32'ha5, {24'h0, rx});
    rchk("ctrl write_collision_flag", ssp_pkg::ADDR_CTRL1, 32'ha0);
    rchk("ist", ssp_pkg::ADDR_IST, 32'h3);
    ssp_peer_inst.load(8'h96);
    apb(1'h1, ssp_pkg::ADDR_BUF, 32'h11);
    wait_idle();
    rchk("ctrl no ovf", ssp_pkg::ADDR_CTRL1, 32'ha0);
    rchk("master buf", ssp_pkg::ADDR_BUF, 32'h96);
    chk("peer rx 2", 32'h11, {24'h0, rx});
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'h1, ssp_pkg::ADDR_IEN, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'h1, ssp_pkg::ADDR_IEN, 32'h7);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'h1, ssp_pkg::ADDR_ICLR, 32'h7);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'h1, ssp_pkg::ADDR_CTRL1, 32'h20);
    rchk("write_collision_flag cleared", ssp_pkg::ADDR_CTRL1, 32'h20);
    $display("master test done");
    apb(1'h1, ssp_pkg::ADDR_CTRL1, 32'h25);
    slave_byte(8'hc3);
    rchk("slave full", ssp_pkg::ADDR_STAT, 32'h1);
    slave_byte(8'h81);
    rchk("ctrl ovf", ssp_pkg::ADDR_CTRL1, 32'h65);
    rchk("kept byte", ssp_pkg::ADDR_BUF, 32'hc3);
    rchk("ist ovf", ssp_pkg::ADDR_IST, 32'h5);
    apb(1'h1, ssp_pkg::ADDR_CTRL1, 32'h25);
    slave_byte(8'h42);
    rchk("slave buf", ssp_pkg::ADDR_BUF, 32'h42);
    rchk("no ovf", ssp_pkg::ADDR_CTRL1, 32'h25);
    $display("slave test done");
    apb(1'h1, ssp_pkg::ADDR_CTRL1, 32'h0);
    chk("pins off", {24'h0, gpio}, {24'h0, pin});
    apb(1'h1, ssp_pkg::ADDR_CTRL1, 32'h20);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("reset pins 2", {24'h0, gpio}, {24'h0, pin});
    chk("reset irq", 32'h0, {31'h0, irq});
    presetn <= 1'h1;
    rchk("ctrl reset 2", ssp_pkg::ADDR_CTRL1, 32'h0);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
